// ### hw/ssa_pkg.sv
// Shared constants and types of the SMBus slave with alert and standby.
// Assumes one link-side clock that oversamples the bus and one system clock.
package ssa_pkg;

  // ************************************************************
  // Bus addresses
  // ************************************************************
  localparam logic [6:0] OWN_ADDR_STD = 7'h4C;
  localparam logic [6:0] OWN_ADDR_ALT = 7'h4D;
  localparam logic [6:0] ALERT_RESPONSE_ADDR = 7'h0C;

  // ************************************************************
  // Register pointer values
  // ************************************************************
  localparam logic [7:0] RD_LOCAL = 8'h00;
  localparam logic [7:0] RD_EXT_HI = 8'h01;
  localparam logic [7:0] RD_STATUS = 8'h02;
  localparam logic [7:0] RD_CFG = 8'h03;
  localparam logic [7:0] RD_RATE = 8'h04;
  localparam logic [7:0] RD_LHI = 8'h05;
  localparam logic [7:0] RD_LLO = 8'h06;
  localparam logic [7:0] RD_EHI = 8'h07;
  localparam logic [7:0] RD_ELO = 8'h08;
  localparam logic [7:0] WR_CFG = 8'h09;
  localparam logic [7:0] WR_RATE = 8'h0A;
  localparam logic [7:0] WR_LHI = 8'h0B;
  localparam logic [7:0] WR_LLO = 8'h0C;
  localparam logic [7:0] WR_EHI = 8'h0D;
  localparam logic [7:0] WR_ELO = 8'h0E;
  localparam logic [7:0] WR_ONE_SHOT = 8'h0F;
  localparam logic [7:0] RD_EXT_LO = 8'h10;
  localparam logic [7:0] RW_OFS_HI = 8'h11;
  localparam logic [7:0] RW_OFS_LO = 8'h12;
  localparam logic [7:0] RW_EHI_LO = 8'h13;
  localparam logic [7:0] RW_ELO_LO = 8'h14;
  localparam logic [7:0] RW_ETHERM = 8'h19;
  localparam logic [7:0] RW_LTHERM = 8'h20;
  localparam logic [7:0] RW_HYST = 8'h21;
  localparam logic [7:0] RW_CONSEC = 8'h22;
  localparam logic [7:0] RD_MFR_ID = 8'hFE;
  localparam logic [7:0] RD_REV = 8'hFF;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int CFG_ALERT_MASK_BIT = 7;
  localparam int CFG_STANDBY_BIT = 6;
  localparam int CONSEC_TIMEOUT_BIT = 7;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h08;
  localparam logic [7:0] RST_LIMIT_HI = 8'h55;
  localparam logic [7:0] RST_HYST = 8'h0A;
  localparam logic [7:0] RST_CONSEC = 8'h01;
  localparam logic [7:0] NO_DATA = 8'h00;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int TIMEOUT_MS = 25;
  localparam int LINK_CLK_HZ = 15625000;
  localparam int TIMEOUT_CYC = (LINK_CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int TMO_W = 20;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_WR_BYTE, S_WR_ACK, S_RD_BYTE, S_RD_ACK
  } ssa_bus_state_t;

  typedef struct packed {
    logic [7:0] local_temp;
    logic [7:0] ext_hi;
    logic [7:0] ext_lo;
    logic open_fault;
  } ssa_meas_t;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] rate;
    logic [7:0] lhi;
    logic [7:0] llo;
    logic [7:0] ehi;
    logic [7:0] elo;
    logic [7:0] ofs_hi;
    logic [7:0] ofs_lo;
    logic [7:0] ehi_lo;
    logic [7:0] elo_lo;
    logic [7:0] etherm;
    logic [7:0] ltherm;
    logic [7:0] hyst;
    logic [7:0] consec;
  } ssa_regs_t;

endpackage

// ### hw/ssa_top.sv
// SMBus slave port with alert output, alert response and standby control.
// Assumes the conversion datapath sits on clock and hands in measurements.
module ssa_top #(
  parameter bit ALT_ADDRESS = 1'b0,
  parameter logic [7:0] MFR_ID = 8'h5A, // Arbitrary identity value.
  parameter logic [7:0] DIE_REV = 8'h01, // Arbitrary identity value.
  parameter int TIMEOUT_CYC = ssa_pkg::TIMEOUT_CYC
) (
  input wire logic clock, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic ce, // Clock enable; low freezes all state except the link-side synchronisers.
  input wire logic link_clk, // Clock that oversamples the bus pins.
  input wire logic scl_i, // Serial clock pin level.
  input wire logic serial_data_line_i, // Serial data pin level.
  output logic serial_data_line_o, // Serial data drive value, always low.
  output logic serial_data_line_oe_n, // Low while pulling serial data low.
  output logic alert_o, // Alert drive value, always low.
  output logic alert_oe_n, // Low while pulling the alert line low.
  input wire logic meas_valid, // One-cycle pulse with a finished conversion.
  input wire ssa_pkg::ssa_meas_t meas, // Conversion result with meas_valid.
  output logic conv_start, // One-cycle pulse to start a single conversion.
  output logic standby // High while conversions must be inhibited.
);

  // ************************************************************
  // Link domain state
  // ************************************************************
  typedef struct packed {
    logic [2:0] scl;
    logic [2:0] sda;
    logic [1:0] ce;
    logic [2:0] req;
  } ssa_lsync_t;

  typedef struct packed {
    ssa_lsync_t syn;
    ssa_pkg::ssa_bus_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [1:0] bidx;
    logic rw;
    logic alert_response_addr;
    logic drv_n;
    logic alert_n;
    logic [ssa_pkg::TMO_W-1:0] tmo;
    logic osh_tgl;
    logic [7:0] ptr;
    ssa_pkg::ssa_regs_t regs;
    ssa_pkg::ssa_meas_t val;
  } ssa_link_t;

  typedef struct packed {
    logic [1:0] stby;
    logic [2:0] osh;
    logic [1:0] ack;
    logic req_tgl;
    ssa_pkg::ssa_meas_t word;
    logic pend;
    logic conv_start;
    logic standby;
  } ssa_sys_t;

  ssa_link_t l_reg, l_next;
  ssa_sys_t s_reg, s_next;
  logic [6:0] own_addr;
  logic lhi_al, llo_al, ehi_al, elo_al, lth_al, eth_al, cause;
  logic [7:0] status;

  assign own_addr = ALT_ADDRESS ? ssa_pkg::OWN_ADDR_ALT : ssa_pkg::OWN_ADDR_STD;

  // ************************************************************
  // Read decode
  // ************************************************************
  function automatic logic [7:0] rd_mux(input ssa_pkg::ssa_regs_t g,
                                        input ssa_pkg::ssa_meas_t v,
                                        input logic [7:0] stat,
                                        input logic [7:0] p);
    logic [7:0] d;
    d = ssa_pkg::NO_DATA;
    unique case (p)
      ssa_pkg::RD_LOCAL: d = v.local_temp;
      ssa_pkg::RD_EXT_HI: d = v.ext_hi;
      ssa_pkg::RD_STATUS: d = stat;
      ssa_pkg::RD_CFG: d = g.cfg;
      ssa_pkg::RD_RATE: d = g.rate;
      ssa_pkg::RD_LHI: d = g.lhi;
      ssa_pkg::RD_LLO: d = g.llo;
      ssa_pkg::RD_EHI: d = g.ehi;
      ssa_pkg::RD_ELO: d = g.elo;
      ssa_pkg::RD_EXT_LO: d = v.ext_lo;
      ssa_pkg::RW_OFS_HI: d = g.ofs_hi;
      ssa_pkg::RW_OFS_LO: d = g.ofs_lo;
      ssa_pkg::RW_EHI_LO: d = g.ehi_lo;
      ssa_pkg::RW_ELO_LO: d = g.elo_lo;
      ssa_pkg::RW_ETHERM: d = g.etherm;
      ssa_pkg::RW_LTHERM: d = g.ltherm;
      ssa_pkg::RW_HYST: d = g.hyst;
      ssa_pkg::RW_CONSEC: d = g.consec;
      ssa_pkg::RD_MFR_ID: d = MFR_ID;
      ssa_pkg::RD_REV: d = DIE_REV;
      default: d = ssa_pkg::NO_DATA;
    endcase
    return d;
  endfunction

  // ************************************************************
  // Limit comparison
  // ************************************************************
  // strict high, inclusive low.
  // Limits are compared live, so a new limit written in standby acts at once.
  always_comb begin
    lhi_al = $signed(l_reg.val.local_temp) > $signed(l_reg.regs.lhi);
    llo_al = $signed(l_reg.val.local_temp) <= $signed(l_reg.regs.llo);
    ehi_al = $signed({l_reg.val.ext_hi, l_reg.val.ext_lo[7:5]})
             > $signed({l_reg.regs.ehi, l_reg.regs.ehi_lo[7:5]});
    elo_al = $signed({l_reg.val.ext_hi, l_reg.val.ext_lo[7:5]})
             <= $signed({l_reg.regs.elo, l_reg.regs.elo_lo[7:5]});
    lth_al = $signed(l_reg.val.local_temp) > $signed(l_reg.regs.ltherm);
    eth_al = $signed(l_reg.val.ext_hi) > $signed(l_reg.regs.etherm);
    cause = lhi_al | llo_al | ehi_al | elo_al | l_reg.val.open_fault;
    status = {1'b0, lhi_al, llo_al, ehi_al, elo_al, l_reg.val.open_fault,
              eth_al, lth_al};
  end

  // ************************************************************
  // Link domain bus engine
  // ************************************************************
  always_comb begin
    ssa_link_t n;
    ssa_link_t hold;
    logic scl_rise, scl_fall, start_c, stop_c, sda, ara_ok, act;
    logic [7:0] rdat;
    n = l_reg;
    hold = l_reg;
    ara_ok = 1'b0;
    n.syn.scl = {l_reg.syn.scl[1:0], scl_i};
    n.syn.sda = {l_reg.syn.sda[1:0], serial_data_line_i};
    n.syn.ce = {l_reg.syn.ce[0], ce};
    n.syn.req = {l_reg.syn.req[1:0], s_reg.req_tgl};
    sda = l_reg.syn.sda[1];
    scl_rise = l_reg.syn.scl[1] & ~l_reg.syn.scl[2];
    scl_fall = ~l_reg.syn.scl[1] & l_reg.syn.scl[2];
    start_c = l_reg.syn.scl[1] & l_reg.syn.scl[2] & l_reg.syn.sda[2] & ~sda;
    stop_c = l_reg.syn.scl[1] & l_reg.syn.scl[2] & ~l_reg.syn.sda[2] & sda;
    act = (l_reg.syn.scl[1] ^ l_reg.syn.scl[2]) | (sda ^ l_reg.syn.sda[2]);
    rdat = rd_mux(l_reg.regs, l_reg.val, status, l_reg.ptr);

    // values only change when the system side accepted a result.
    if (l_reg.syn.req[2] != l_reg.syn.req[1]) begin
      n.val = s_reg.word;
    end

    unique case (l_reg.st)
      ssa_pkg::S_IDLE: begin
        n.drv_n = 1'b1;
      end
      ssa_pkg::S_ADDR: begin
        if (scl_rise) begin
          n.sh = {l_reg.sh[6:0], sda};
          n.cnt = l_reg.cnt + 4'h1;
        end else if (scl_fall && l_reg.cnt == 4'h8) begin
          n.rw = l_reg.sh[0];
          n.alert_response_addr = 1'b0;
          if (l_reg.sh[7:1] == own_addr) begin
            n.drv_n = 1'b0;
            n.st = ssa_pkg::S_ADDR_ACK;
          // answer only while alert is low.
          end else if (l_reg.sh[7:1] == ssa_pkg::ALERT_RESPONSE_ADDR && l_reg.sh[0]
                       && !l_reg.alert_n) begin
            n.drv_n = 1'b0;
            n.alert_response_addr = 1'b1;
            n.st = ssa_pkg::S_ADDR_ACK;
          end else begin
            n.st = ssa_pkg::S_IDLE;
          end
        end
      end
      ssa_pkg::S_ADDR_ACK: begin
        if (scl_fall) begin
          n.cnt = 4'h0;
          n.bidx = 2'h0;
          if (l_reg.rw) begin
            n.sh = l_reg.alert_response_addr ? {own_addr, 1'b1} : rdat;
            n.drv_n = l_reg.alert_response_addr ? own_addr[6] : rdat[7];
            n.st = ssa_pkg::S_RD_BYTE;
          end else begin
            n.drv_n = 1'b1;
            n.st = ssa_pkg::S_WR_BYTE;
          end
        end
      end
      ssa_pkg::S_WR_BYTE: begin
        if (scl_rise) begin
          n.sh = {l_reg.sh[6:0], sda};
          n.cnt = l_reg.cnt + 4'h1;
        end else if (scl_fall && l_reg.cnt == 4'h8) begin
          if (l_reg.bidx == 2'h2) begin
            n.st = ssa_pkg::S_IDLE;
          end else begin
            n.drv_n = 1'b0;
            n.st = ssa_pkg::S_WR_ACK;
            if (l_reg.bidx == 2'h0) begin
              n.ptr = l_reg.sh;
            end else begin
              unique case (l_reg.ptr)
                ssa_pkg::WR_CFG: n.regs.cfg = l_reg.sh;
                ssa_pkg::WR_RATE: n.regs.rate = l_reg.sh;
                ssa_pkg::WR_LHI: n.regs.lhi = l_reg.sh;
                ssa_pkg::WR_LLO: n.regs.llo = l_reg.sh;
                ssa_pkg::WR_EHI: n.regs.ehi = l_reg.sh;
                ssa_pkg::WR_ELO: n.regs.elo = l_reg.sh;
                ssa_pkg::WR_ONE_SHOT: n.osh_tgl = ~l_reg.osh_tgl;
                ssa_pkg::RW_OFS_HI: n.regs.ofs_hi = l_reg.sh;
                ssa_pkg::RW_OFS_LO: n.regs.ofs_lo = l_reg.sh;
                ssa_pkg::RW_EHI_LO: n.regs.ehi_lo = l_reg.sh;
                ssa_pkg::RW_ELO_LO: n.regs.elo_lo = l_reg.sh;
                ssa_pkg::RW_ETHERM: n.regs.etherm = l_reg.sh;
                ssa_pkg::RW_LTHERM: n.regs.ltherm = l_reg.sh;
                ssa_pkg::RW_HYST: n.regs.hyst = l_reg.sh;
                ssa_pkg::RW_CONSEC: n.regs.consec = l_reg.sh;
                default: n.regs = l_reg.regs;
              endcase
            end
          end
        end
      end
      ssa_pkg::S_WR_ACK: begin
        if (scl_fall) begin
          n.drv_n = 1'b1;
          n.cnt = 4'h0;
          n.bidx = l_reg.bidx + 2'h1;
          n.st = ssa_pkg::S_WR_BYTE;
        end
      end
      ssa_pkg::S_RD_BYTE: begin
        if (scl_rise) begin
          n.cnt = l_reg.cnt + 4'h1;
          if (l_reg.drv_n && !sda) begin
            n.st = ssa_pkg::S_IDLE;
          end
        end else if (scl_fall) begin
          if (l_reg.cnt == 4'h8) begin
            n.drv_n = 1'b1;
            n.st = ssa_pkg::S_RD_ACK;
          end else begin
            n.sh = {l_reg.sh[6:0], 1'b0};
            n.drv_n = l_reg.sh[6];
          end
        end
      end
      ssa_pkg::S_RD_ACK: begin
        if (scl_rise) begin
          ara_ok = l_reg.alert_response_addr;
          n.st = ssa_pkg::S_IDLE;
        end
      end
      default: n.st = ssa_pkg::S_IDLE;
    endcase

    if (l_reg.st == ssa_pkg::S_IDLE || act) begin
      n.tmo = '0;
    end else begin
      n.tmo = l_reg.tmo + 1'b1;
      if (l_reg.regs.consec[ssa_pkg::CONSEC_TIMEOUT_BIT]
          && l_reg.tmo >= TIMEOUT_CYC[ssa_pkg::TMO_W-1:0]) begin
        n.st = ssa_pkg::S_IDLE;
        n.drv_n = 1'b1;
      end
    end

    // a new start restarts address reception from any state unless the engine is frozen.
    if (start_c) begin
      n.st = ssa_pkg::S_ADDR;
      n.cnt = 4'h0;
      n.drv_n = 1'b1;
    end else if (stop_c) begin
      n.st = ssa_pkg::S_IDLE;
      n.drv_n = 1'b1;
    end

    // release only on a served alert response read; a present cause wins.
    // the mask bit keeps the pin released.
    n.alert_n = (l_reg.alert_n | ara_ok)
                & ~(cause & ~l_reg.regs.cfg[ssa_pkg::CFG_ALERT_MASK_BIT]);

    // Synchronisers keep running while the rest is frozen.
    if (!l_reg.syn.ce[1]) begin
      hold.syn = n.syn;
      n = hold;
    end
    l_next = n;
  end

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      l_reg <= '0;
      l_reg.st <= ssa_pkg::S_IDLE;
      l_reg.drv_n <= 1'b1;
      l_reg.alert_n <= 1'b1;
      l_reg.regs.rate <= ssa_pkg::RST_RATE;
      l_reg.regs.lhi <= ssa_pkg::RST_LIMIT_HI;
      l_reg.regs.ehi <= ssa_pkg::RST_LIMIT_HI;
      l_reg.regs.etherm <= ssa_pkg::RST_LIMIT_HI;
      l_reg.regs.ltherm <= ssa_pkg::RST_LIMIT_HI;
      l_reg.regs.hyst <= ssa_pkg::RST_HYST;
      l_reg.regs.consec <= ssa_pkg::RST_CONSEC;
    end else begin
      l_reg <= l_next;
    end
  end

  // ************************************************************
  // System domain conversion control
  // ************************************************************
  always_comb begin
    ssa_sys_t n;
    logic osh_evt, busy;
    n = s_reg;
    n.stby = {s_reg.stby[0], l_reg.regs.cfg[ssa_pkg::CFG_STANDBY_BIT]};
    n.osh = {s_reg.osh[1:0], l_reg.osh_tgl};
    n.ack = {s_reg.ack[0], l_reg.syn.req[2]};
    n.standby = s_reg.stby[1];
    n.conv_start = 1'b0;
    osh_evt = s_reg.osh[2] ^ s_reg.osh[1];
    busy = s_reg.ack[1] != s_reg.req_tgl;
    // one conversion, then back to standby.
    if (osh_evt && s_reg.stby[1]) begin
      n.pend = 1'b1;
      n.conv_start = 1'b1;
    end
    // results are dropped in standby unless a single shot is running.
    // A result arriving while the last one still crosses is dropped too.
    if (meas_valid && (!s_reg.stby[1] || s_reg.pend) && !busy) begin
      n.word = meas;
      n.req_tgl = ~s_reg.req_tgl;
      n.pend = 1'b0;
    end
    s_next = ce ? n : s_reg;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign serial_data_line_o = 1'b0;
  assign alert_o = 1'b0;
  assign serial_data_line_oe_n = l_reg.drv_n;
  assign alert_oe_n = l_reg.alert_n;
  assign conv_start = s_reg.conv_start;
  assign standby = s_reg.standby;

endmodule

// ### test/ssa_top_asserts.sv
// Checker for the SMBus slave port: data drive timing, pulses, alert release.
// Assumes the host keeps each bus clock phase well above the input sync delay.
module ssa_top_asserts (
  input wire logic clock, // System clock.
  input wire logic rst, // Reset, active high.
  input wire logic link_clk, // Bus sampling clock.
  input wire logic scl_i, // Bus clock level.
  input wire logic serial_data_line_i, // Bus data level.
  input wire logic serial_data_line_o, // Data drive value.
  input wire logic serial_data_line_oe_n, // Data drive enable.
  input wire logic alert_o, // Alert drive value.
  input wire logic alert_oe_n, // Alert drive enable.
  input wire logic conv_start, // Conversion pulse.
  input wire logic standby // Standby level.
);
  // ************************************************************
  // Properties
  // ************************************************************
  sequence s_start;
    $fell(serial_data_line_i) && scl_i;
  endsequence
  sequence s_drive_at_rise;
    $rose(scl_i) && !serial_data_line_oe_n;
  endsequence
  a_pins_open_drain: assert property (@(posedge link_clk) disable iff (rst)
    !serial_data_line_o && !alert_o) else $error("Drive value is not low.");
  a_data_moves_low: assert property (@(posedge link_clk) disable iff (rst)
    $changed(serial_data_line_oe_n) |-> !scl_i) else $error("Data moved with clock high.");
  a_start_released: assert property (@(posedge link_clk) disable iff (rst)
    s_start |-> serial_data_line_oe_n) else $error("Data driven at start.");
  a_ack_holds: assert property (@(posedge link_clk) disable iff (rst)
    $fell(serial_data_line_oe_n) |=> !serial_data_line_oe_n [*4])
    else $error("Low drive too short.");
  a_bit_stable_high: assert property (@(posedge link_clk) disable iff (rst)
    s_drive_at_rise |=> !serial_data_line_oe_n [*6]) else $error("Bit lost in high phase.");
  a_conv_one_pulse: assert property (@(posedge clock) disable iff (rst)
    conv_start |=> !conv_start) else $error("Conversion pulse too long.");
  a_conv_in_standby: assert property (@(posedge clock) disable iff (rst)
    conv_start |-> standby) else $error("Conversion pulse outside standby.");
  a_alert_release: assert property (@(posedge link_clk) disable iff (rst)
    $rose(alert_oe_n) |-> scl_i) else $error("Alert released off the bus clock.");
endmodule

bind ssa_top ssa_top_asserts u_chk (
  .clock(clock), .rst(rst), .link_clk(link_clk), .scl_i(scl_i),
  .serial_data_line_i(serial_data_line_i), .serial_data_line_o(serial_data_line_o),
  .serial_data_line_oe_n(serial_data_line_oe_n), .alert_o(alert_o),
  .alert_oe_n(alert_oe_n), .conv_start(conv_start), .standby(standby)
);

// ### test/ssa_host_model.sv
// Bus host model: bit-banged SMBus master with open-drain drives.
// Assumes the bench resolves both wires with pull-ups.
module ssa_host_model #(
  parameter int HALF = 560
) (
  output logic scl_low, // High while pulling the clock line low.
  output logic sda_low, // High while pulling the data line low.
  input wire logic sda // Resolved data line.
);
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************************************
  // Bus cycles
  // ************************************************************
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic start();
    sda_low = 1'b1;
    #HALF;
    scl_low = 1'b1;
    #HALF;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic mack, output logic [7:0] q,
      output logic ack);
    logic [8:0] r;
    for (int i = 8; i >= 0; i--) begin
      sda_low = (i == 0) ? mack : !d[i - 1];
      #HALF;
      scl_low = 1'b0;
      #HALF;
      r[i] = sda;
      scl_low = 1'b1;
    end
    q = r[8:1];
    ack = !r[0];
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #HALF;
    scl_low = 1'b0;
    #HALF;
    sda_low = 1'b0;
    #HALF;
  endtask
endmodule

// ### test/tb_ssa_top.sv
// Bench for the SMBus slave port: pointer, standby, limits and alert service.
// Assumes the host model drives the bus and both wires have pull-ups.
module tb_ssa_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic meas_valid = 1'b0;
  ssa_pkg::ssa_meas_t meas = '0;
  logic sda_oe_n, alert_oe_n, conv_start, standby, scl_low, sda_low;
  logic [6:0] dev = ssa_pkg::OWN_ADDR_STD;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int conv_cnt = 0;
  wire logic scl_line = !scl_low;
  wire logic sda_line = !sda_low && sda_oe_n;
  // ************************************************************
  // Clocks, parts and helpers
  // ************************************************************
  initial begin
    forever #2.5 clock = ~clock;
  end
  initial begin
    #3;
    forever #32 link_clk = ~link_clk;
  end
  ssa_top #(.TIMEOUT_CYC(200)) DUT (
    .clock(clock), .rst(rst), .ce(1'b1), .link_clk(link_clk), .scl_i(scl_line),
    .serial_data_line_i(sda_line), .serial_data_line_o(),
    .serial_data_line_oe_n(sda_oe_n), .alert_o(), .alert_oe_n(alert_oe_n),
    .meas_valid(meas_valid), .meas(meas), .conv_start(conv_start), .standby(standby));
  ssa_host_model host (.scl_low(scl_low), .sda_low(sda_low), .sda(sda_line));
  always @(posedge clock) begin
    cyc++;
    if (conv_start === 1'b1) conv_cnt++;
    if (cyc == 95000) begin
      fails++;
      test_done();
    end
  end
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [23:0] b, input int n,
      output logic [3:0] ak);
    logic [7:0] q;
    logic k;
    ak = 4'h0;
    host.start();
    host.xbyte({a, 1'b0}, 1'b0, q, k);
    ak[0] = k;
    for (int i = 0; i < n; i++) begin
      host.xbyte(b[23 - 8 * i -: 8], 1'b0, q, k);
      ak[i + 1] = k;
    end
    host.stop();
  endtask
  // The host never acknowledges read data, so each read is one byte long.
  task automatic rd(input logic [6:0] a, output logic [7:0] q, output logic ak);
    logic k;
    host.start();
    host.xbyte({a, 1'b1}, 1'b0, q, ak);
    if (ak === 1'b1) host.xbyte(8'hFF, 1'b0, q, k);
    host.stop();
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_pointer();
    logic [7:0] q;
    logic [3:0] ak;
    logic k;
    meas = {8'h30, 8'h30, 8'h00, 1'b0};
    @(posedge clock);
    #1 meas_valid = 1'b1;
    @(posedge clock);
    #1 meas_valid = 1'b0;
    repeat (100) @(posedge clock);
    // Zero values sit on the zero low limits out of reset, so the alert is already low.
    rd(ssa_pkg::ALERT_RESPONSE_ADDR, q, k);
    chk("reset alert reply", {ssa_pkg::OWN_ADDR_STD, 1'b1}, q);
    chk("alert idle", 8'h01, {7'h00, alert_oe_n});
    wr(dev, {ssa_pkg::RD_LHI, 16'h0000}, 1, ak);
    chk("pointer acks", 8'h03, {4'h0, ak});
    for (int i = 0; i < 2; i++) begin
      rd(dev, q, k);
      chk("high limit", ssa_pkg::RST_LIMIT_HI, q);
    end
  endtask
  task automatic t_foreign();
    logic [3:0] ak;
    logic [6:0] bad [2] = '{7'h4D, 7'h4E};
    for (int i = 0; i < 2; i++) begin
      wr(bad[i], 24'h000000, 0, ak);
      chk("foreign ack", 8'h00, {4'h0, ak});
    end
  endtask
  task automatic t_standby();
    logic [3:0] ak;
    int c;
    wr(dev, {ssa_pkg::WR_CFG, 8'h40, 8'h00}, 2, ak);
    chk("standby", 8'h01, {7'h00, standby});
    c = conv_cnt;
    wr(dev, {ssa_pkg::WR_ONE_SHOT, 8'hA5, 8'h00}, 2, ak);
    chk("one shot", 8'h01, 8'(conv_cnt - c));
    chk("back to standby", 8'h01, {7'h00, standby});
  endtask
  task automatic t_limit();
    logic [7:0] q;
    logic [3:0] ak;
    logic k;
    wr(dev, {ssa_pkg::WR_LHI, 8'h20, 8'h11}, 3, ak);
    chk("limit acks", 8'h07, {4'h0, ak});
    chk("alert low", 8'h00, {7'h00, alert_oe_n});
    wr(dev, {ssa_pkg::RD_LHI, 16'h0000}, 1, ak);
    rd(dev, q, k);
    chk("limit readback", 8'h20, q);
    wr(dev, {ssa_pkg::WR_ONE_SHOT, 16'h0000}, 1, ak);
    rd(dev, q, k);
    chk("write-only read", ssa_pkg::NO_DATA, q);
  endtask
  task automatic t_alert();
    logic [7:0] q;
    logic [3:0] ak;
    logic k;
    wr(dev, {ssa_pkg::WR_LHI, 8'h30, 8'h00}, 2, ak);
    chk("alert kept", 8'h00, {7'h00, alert_oe_n});
    rd(ssa_pkg::ALERT_RESPONSE_ADDR, q, k);
    chk("alert reply", {ssa_pkg::OWN_ADDR_STD, 1'b1}, q);
    chk("alert freed", 8'h01, {7'h00, alert_oe_n});
    rd(ssa_pkg::ALERT_RESPONSE_ADDR, q, k);
    chk("idle reply ack", 8'h00, {7'h00, k});
  endtask
  // Reset spans eight link cycles so that both clock domains see it.
  initial begin
    repeat (8) @(posedge link_clk);
    @(posedge clock);
    #1 rst = 1'b0;
    repeat (8) @(posedge link_clk);
    t_pointer();
    t_foreign();
    t_standby();
    t_limit();
    t_alert();
    test_done();
  end
endmodule
